/* File: rtl/rtcsr_defs.vh */
// Constants for the remote terminal command and status register bank.
// Assumes a 10 MHz ref_clk and a 16-bit word-addressed host port.
`ifndef RTCSR_DEFS_VH
`define RTCSR_DEFS_VH

// Register word addresses
`define RTCSR_ADDR_CMD1      8'h02
`define RTCSR_ADDR_CWP1      8'h03
`define RTCSR_ADDR_CMD2      8'h04
`define RTCSR_ADDR_CWP2      8'h05
`define RTCSR_ADDR_BASE1     8'h19
`define RTCSR_ADDR_STAT1     8'h1A
`define RTCSR_ADDR_BASE2     8'h22
`define RTCSR_ADDR_STAT2     8'h23

// Reset values
`define RTCSR_RST_ZERO       16'h0000
`define RTCSR_RST_BASE1      16'h0400
`define RTCSR_RST_BASE2      16'h0600

// Descriptor base: only bits 14-9 hold data
`define RTCSR_BASE_WMASK     16'h7E00

// Status word bits layout
`define RTCSR_STAT_SNDCLR    15
`define RTCSR_STAT_MSGERR    10
`define RTCSR_STAT_INSTR     9
`define RTCSR_STAT_SERVICE_REQUEST_FLAG    8
`define RTCSR_STAT_BCAST     4
`define RTCSR_STAT_BUSY      3
`define RTCSR_STAT_SUBSYSTEM_FAULT_FLAG     2
`define RTCSR_STAT_WMASK     16'h830F
`define RTCSR_STAT_CLRMASK   16'h83EF
`define RTCSR_STAT_TXW       11

// Update delay after bus activity
`define RTCSR_UPD_NS         5000
`define RTCSR_CLK_NS         100
`define RTCSR_UPD_CYC        ((`RTCSR_UPD_NS + `RTCSR_CLK_NS - 1) / `RTCSR_CLK_NS)
`define RTCSR_CNT_W          8

`endif

/* File: rtl/rtcsr_delay.v */
// One-shot delay timer: a pulse on start gives a pulse on done CYC cycles later.
// Assumes start comes from logic on ref_clk; a new start restarts the count.
`default_nettype none
module rtcsr_delay #(
  parameter CYC = 50,
  parameter W   = 8
) (
  input  wire         ref_clk,
  input  wire         rst_n,
  input  wire         start,
  output reg          done_r
);
  localparam [31:0]  LOAD_I = CYC - 1;
  localparam [W-1:0] LOAD   = LOAD_I[W-1:0];
  localparam [W-1:0] ZERO   = {W{1'b0}};
  localparam [W-1:0] ONE    = {{(W-1){1'b0}}, 1'b1};

  reg [W-1:0] cnt_r;
  reg         run_r;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_r  <= ZERO;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        cnt_r <= LOAD;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r == ZERO) begin
          run_r  <= 1'b0;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r - ONE;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/rtcsr_stat.v */
// Status word bits register of one remote terminal.
// Assumes its strobes come from the message engine on ref_clk.
`default_nettype none
`include "rtcsr_defs.vh"
module rtcsr_stat (
  input  wire         ref_clk,
  input  wire         rst_n,
  input  wire         soft_rst,
  input  wire         wr_en,
  input  wire [15:0]  wdata,
  input  wire         sts_sent,
  input  wire         sts_reuse,
  input  wire         mc16_rx,
  input  wire         vec_opt,
  input  wire         msg_done,
  input  wire         msg_err,
  input  wire         bcast,
  output reg  [15:0]  stat_r
);
  reg [15:0] stat_nxt;
  wire [15:0] wmask = `RTCSR_STAT_WMASK;
  wire [15:0] cmask = `RTCSR_STAT_CLRMASK;

  always @* begin
    stat_nxt = stat_r;
    if (msg_done) begin
      stat_nxt[`RTCSR_STAT_MSGERR] = msg_err;
      stat_nxt[`RTCSR_STAT_BCAST]  = bcast;
    end
    // Mode code replies reuse the status, so they neither fire nor cancel the clear
    if (sts_sent && !sts_reuse && stat_r[`RTCSR_STAT_SNDCLR])
      stat_nxt = stat_nxt & ~cmask;
    if (mc16_rx && !vec_opt)
      stat_nxt[`RTCSR_STAT_SERVICE_REQUEST_FLAG] = 1'b0;
    // A host write in the same cycle wins so the new value is not lost
    if (wr_en)
      stat_nxt = (stat_nxt & ~wmask) | (wdata & wmask);
  end

  always @(posedge ref_clk) begin
    if (!rst_n || soft_rst)
      stat_r <= `RTCSR_RST_ZERO;
    else
      stat_r <= stat_nxt;
  end
endmodule
`default_nettype wire

/* File: rtl/rtcsr_regs.v */
// Command and status register bank for two remote terminals.
// Assumes the message engine and host port run on ref_clk; rst_n is the master reset pin.
// Behaviour
// - Capture last valid command word per terminal
// - Command word updates 5 us after activity
// - Command and pointer: master reset clears only
// - Hold control word address of captured command
// - Pointer loads 5 us after activity
// - Base resets to 0x0400 / 0x0600
// - Base bit 15, bits 8:0 read zero
// - Status bits clear on either reset
// - Status bits 14-10, 7-4 read-only
// - Device keeps message error and broadcast
// - Other status bits host writable, active high
// - Bits 10-0 feed outgoing status word
// - Host bits persist without send-then-clear
// - Send-then-clear clears bits after status
// - Mode code status replies skip the clear
// - Busy bit set by host write, copied to busy_r
// - Vector mode code clears service request unless vector_mode_option is set
`default_nettype none
`include "rtcsr_defs.vh"
module rtcsr_regs #(
  parameter UPD_CYC = `RTCSR_UPD_CYC,
  parameter CNT_W   = `RTCSR_CNT_W
) (
  input  wire         ref_clk,
  input  wire         rst_n,
  input  wire [1:0]   terminal_soft_reset,
  input  wire         host_cs,
  input  wire         host_wr,
  input  wire         host_rd,
  input  wire [7:0]   host_addr,
  input  wire [15:0]  host_wdata,
  output reg  [15:0]  host_rdata_r,
  input  wire [1:0]   cmd_seen,
  input  wire [31:0]  cmd_word_in,
  input  wire [31:0]  cw_addr_in,
  input  wire [1:0]   sts_sent,
  input  wire [1:0]   sts_reuse,
  input  wire [1:0]   mc16_rx,
  input  wire [1:0]   vector_mode_option,
  input  wire [1:0]   msg_done,
  input  wire [1:0]   msg_err_in,
  input  wire [1:0]   bcast_in,
  output reg  [21:0]  sts_bits_r,
  output reg  [1:0]   busy_r,
  output reg  [31:0]  desc_base_r,
  output reg  [31:0]  cap_cmd_r,
  output reg  [31:0]  cw_ptr_r
);
  wire        wr_ok = host_cs & host_wr;
  wire        rd_ok = host_cs & host_rd;
  wire [31:0] stat_w;
  wire [1:0]  upd_done;
  wire [15:0] bmask = `RTCSR_BASE_WMASK;
  reg  [31:0] pend_cmd_r;
  reg  [31:0] pend_cwp_r;
  reg  [15:0] rd_nxt;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_rt
      wire [7:0]  a_base = (i == 0) ? `RTCSR_ADDR_BASE1 : `RTCSR_ADDR_BASE2;
      wire [7:0]  a_stat = (i == 0) ? `RTCSR_ADDR_STAT1 : `RTCSR_ADDR_STAT2;
      wire [15:0] r_base = (i == 0) ? `RTCSR_RST_BASE1 : `RTCSR_RST_BASE2;
      wire [15:0] stat;

      // Held until the delay expires so a half-updated pair is never visible
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          pend_cmd_r[16*i +: 16] <= `RTCSR_RST_ZERO;
          pend_cwp_r[16*i +: 16] <= `RTCSR_RST_ZERO;
        end else if (cmd_seen[i]) begin
          pend_cmd_r[16*i +: 16] <= cmd_word_in[16*i +: 16];
          pend_cwp_r[16*i +: 16] <= cw_addr_in[16*i +: 16];
        end
      end

      // The capture register below adds the last cycle of the wait
      rtcsr_delay #(
        .CYC (UPD_CYC - 1),
        .W   (CNT_W)
      ) u_delay (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .start   (cmd_seen[i]),
        .done_r  (upd_done[i])
      );

      // Soft reset deliberately absent here
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          cap_cmd_r[16*i +: 16] <= `RTCSR_RST_ZERO;
          cw_ptr_r[16*i +: 16]  <= `RTCSR_RST_ZERO;
        end else if (upd_done[i]) begin
          cap_cmd_r[16*i +: 16] <= pend_cmd_r[16*i +: 16];
          cw_ptr_r[16*i +: 16]  <= pend_cwp_r[16*i +: 16];
        end
      end

      always @(posedge ref_clk) begin
        if (!rst_n || terminal_soft_reset[i])
          desc_base_r[16*i +: 16] <= r_base;
        else if (wr_ok && host_addr == a_base)
          desc_base_r[16*i +: 16] <= host_wdata & bmask;
      end

      rtcsr_stat u_stat (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .soft_rst (terminal_soft_reset[i]),
        .wr_en    (wr_ok && host_addr == a_stat),
        .wdata    (host_wdata),
        .sts_sent (sts_sent[i]),
        .sts_reuse(sts_reuse[i]),
        .mc16_rx  (mc16_rx[i]),
        .vec_opt  (vector_mode_option[i]),
        .msg_done (msg_done[i]),
        .msg_err  (msg_err_in[i]),
        .bcast    (bcast_in[i]),
        .stat_r   (stat)
      );
      assign stat_w[16*i +: 16] = stat;

      // One cycle behind the register; the engine reads it at response time
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          sts_bits_r[11*i +: 11] <= 11'h000;
          busy_r[i]              <= 1'b0;
        end else begin
          sts_bits_r[11*i +: 11] <= stat_nxt_view(stat);
          busy_r[i]              <= stat[`RTCSR_STAT_BUSY];
        end
      end
    end
  endgenerate

  function [10:0] stat_nxt_view;
    input [15:0] s;
    begin
      stat_nxt_view = s[10:0];
    end
  endfunction

  always @* begin
    rd_nxt = `RTCSR_RST_ZERO;
    case (host_addr)
      `RTCSR_ADDR_CMD1:  rd_nxt = cap_cmd_r[15:0];
      `RTCSR_ADDR_CWP1:  rd_nxt = cw_ptr_r[15:0];
      `RTCSR_ADDR_CMD2:  rd_nxt = cap_cmd_r[31:16];
      `RTCSR_ADDR_CWP2:  rd_nxt = cw_ptr_r[31:16];
      `RTCSR_ADDR_BASE1: rd_nxt = desc_base_r[15:0];
      `RTCSR_ADDR_STAT1: rd_nxt = stat_w[15:0];
      `RTCSR_ADDR_BASE2: rd_nxt = desc_base_r[31:16];
      `RTCSR_ADDR_STAT2: rd_nxt = stat_w[31:16];
      default:           rd_nxt = `RTCSR_RST_ZERO;
    endcase
  end

  // Read data holds until the next read strobe
  always @(posedge ref_clk) begin
    if (!rst_n)
      host_rdata_r <= `RTCSR_RST_ZERO;
    else if (rd_ok)
      host_rdata_r <= rd_nxt;
  end
endmodule
`default_nettype wire

/* File: bench/rtcsr_regs_checker.sv */
// Assertions on the ports of the two-terminal register bank.
// Bound to rtcsr_regs; sees its ports only.
`default_nettype none
module rtcsr_regs_checker #(
  parameter int UPD_CYC = 50
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [1:0]  terminal_soft_reset,
  input wire logic        host_cs,
  input wire logic        host_wr,
  input wire logic [1:0]  cmd_seen,
  input wire logic [1:0]  mc16_rx,
  input wire logic [1:0]  vector_mode_option,
  input wire logic [21:0] sts_bits_r,
  input wire logic [1:0]  busy_r,
  input wire logic [31:0] desc_base_r,
  input wire logic [31:0] cap_cmd_r,
  input wire logic [31:0] cw_ptr_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  base_rsv_a: assert property ((desc_base_r & 32'h81FF_81FF) == 32'h0000_0000)
    else $error("base reserved bits set");
  stat_rsv_a: assert property ((sts_bits_r & 22'h07_00E0) == 22'h00_0000)
    else $error("status reserved bits set");
  busy_copy_a: assert property (busy_r == {sts_bits_r[14], sts_bits_r[3]})
    else $error("busy output differs from status bit");
  reset_load_a: assert property (disable iff (1'b0) !rst_n |=> desc_base_r == 32'h0600_0400
    && cap_cmd_r == 32'h0000_0000 && cw_ptr_r == 32'h0000_0000) else $error("master reset values wrong");
  soft_reset_a: assert property (terminal_soft_reset[0] |=> desc_base_r[15:0] == 16'h0400
    && $stable(cap_cmd_r) ##1 sts_bits_r[10:0] == 11'h000) else $error("soft reset effect wrong");
  cap_delay_a: assert property ($changed(cap_cmd_r) || $changed(cw_ptr_r)
    |-> $past(cmd_seen, UPD_CYC + 1) != 2'b00) else $error("capture at wrong time");
  cap_late_a: assert property (cmd_seen[0] |=> $stable(cap_cmd_r[15:0]))
    else $error("capture too early");
  vec_clear_a: assert property (mc16_rx[0] && !vector_mode_option[0] && !(host_cs && host_wr)
    |=> ##1 !sts_bits_r[8]) else $error("service request not cleared");
endmodule
bind rtcsr_regs rtcsr_regs_checker #(.UPD_CYC(UPD_CYC)) u_chk (.ref_clk, .rst_n, .terminal_soft_reset,
  .host_cs, .host_wr, .cmd_seen, .mc16_rx, .vector_mode_option, .sts_bits_r, .busy_r, .desc_base_r,
  .cap_cmd_r, .cw_ptr_r);
`default_nettype wire

/* File: bench/rtcsr_bc_model.sv */
// Bus controller stand-in driving command and status events.
// Assumes calls arrive just after a ref_clk rising edge.
`default_nettype none
module rtcsr_bc_model (
  input  wire logic        ref_clk,
  output var  logic [1:0]  cmd_seen,
  output var  logic [31:0] cmd_word_in,
  output var  logic [31:0] cw_addr_in,
  output var  logic [1:0]  sts_sent,
  output var  logic [1:0]  sts_reuse,
  output var  logic [1:0]  mc16_rx,
  output var  logic [1:0]  msg_done,
  output var  logic [1:0]  msg_err_in,
  output var  logic [1:0]  bcast_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {cmd_seen, sts_sent, sts_reuse, mc16_rx, msg_done, msg_err_in, bcast_in} = 14'h0000;
    {cmd_word_in, cw_addr_in} = 64'hA5A5_5A5A_5A5A_A5A5;
  end
  // Words flip once taken, so a late sample sees garbage
  task automatic cmd(input int t, input logic [15:0] w, input logic [15:0] a);
    {cmd_word_in[16*t+:16], cw_addr_in[16*t+:16], cmd_seen[t]} = {w, a, 1'b1};
    @(posedge ref_clk);
    #1 cmd_seen[t] = 1'b0;
    {cmd_word_in, cw_addr_in} = ~{cmd_word_in, cw_addr_in};
  endtask
  // Flags: sent, reuse, vector code, done, error, broadcast
  task automatic ev(input int t, input logic [5:0] v);
    {sts_sent[t], sts_reuse[t], mc16_rx[t], msg_done[t], msg_err_in[t], bcast_in[t]} = v;
    @(posedge ref_clk);
    #1 {sts_sent[t], sts_reuse[t], mc16_rx[t], msg_done[t], msg_err_in[t], bcast_in[t]} = 6'h00;
  endtask
endmodule
`default_nettype wire

/* File: bench/rtcsr_regs_tb.sv */
// Self-checking bench for the two-terminal register bank.
// Assumes the bus controller model and a 10 MHz ref_clk.
`default_nettype none
module rtcsr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int UPD = 3; // Short wait keeps the run brief
  logic        ref_clk = 0, rst_n = 0, host_cs = 0, host_wr = 0, host_rd = 0;
  logic [1:0]  terminal_soft_reset = 0, vector_mode_option = 0, busy_r;
  logic [1:0]  cmd_seen, sts_sent, sts_reuse, mc16_rx, msg_done, msg_err_in, bcast_in;
  logic [7:0]  host_addr = 0;
  logic [15:0] host_wdata = 0, host_rdata_r;
  logic [21:0] sts_bits_r;
  logic [31:0] cmd_word_in, cw_addr_in, desc_base_r, cap_cmd_r, cw_ptr_r;
  int          n_mismatch = 0, total_checks = 0, cyc = 0;
  logic [7:0]  ra [9] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h19, 8'h1A, 8'h22, 8'h23, 8'h7F};
  logic [15:0] rv [9] = '{0, 0, 0, 0, 16'h0400, 0, 16'h0600, 0, 0};
  rtcsr_regs #(.UPD_CYC(UPD)) u_rtcsr_regs (.ref_clk, .rst_n, .terminal_soft_reset, .host_cs, .host_wr,
    .host_rd, .host_addr, .host_wdata, .host_rdata_r, .cmd_seen, .cmd_word_in, .cw_addr_in, .sts_sent,
    .sts_reuse, .mc16_rx, .vector_mode_option, .msg_done, .msg_err_in, .bcast_in, .sts_bits_r, .busy_r,
    .desc_base_r, .cap_cmd_r, .cw_ptr_r);
  rtcsr_bc_model u_bc (.ref_clk, .cmd_seen, .cmd_word_in, .cw_addr_in, .sts_sent, .sts_reuse, .mc16_rx,
    .msg_done, .msg_err_in, .bcast_in);
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    {host_cs, host_wr, host_addr, host_wdata} = {2'b11, a, d};
    @(posedge ref_clk);
    #1 {host_cs, host_wr} = 2'b00;
    // Let an edge pass so the next request never reuses this time step
    @(posedge ref_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    {host_cs, host_rd, host_addr} = {2'b11, a};
    @(posedge ref_clk);
    #1 {host_cs, host_rd} = 2'b00;
    @(posedge ref_clk);
    #1 chk({16'h0000, host_rdata_r}, {16'h0000, e});
  endtask
  // Old pair must stand until the wait ends, new pair just after
  task automatic cap_chk(input int t, input logic [31:0] n);
    repeat (UPD - 1) @(posedge ref_clk);
    #1 chk({cap_cmd_r[16*t+:16], cw_ptr_r[16*t+:16]}, 32'h0000_0000);
    @(posedge ref_clk);
    #1 chk({cap_cmd_r[16*t+:16], cw_ptr_r[16*t+:16]}, n);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1;
    for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
    wr(8'h19, 16'hFFFF);
    rd(8'h19, 16'h7E00);
    wr(8'h1A, 16'hFFFF);
    rd(8'h1A, 16'h830F);
    chk(busy_r, 2'b01);
    u_bc.ev(0, 6'h07);
    rd(8'h1A, 16'h871F);
    chk(sts_bits_r, 22'h00_071F);
    u_bc.ev(0, 6'h30);
    rd(8'h1A, 16'h871F);
    u_bc.ev(0, 6'h20);
    rd(8'h1A, 16'h0410);
    wr(8'h1A, 16'h030F);
    u_bc.ev(0, 6'h20);
    rd(8'h1A, 16'h071F);
    vector_mode_option = 2'b01;
    u_bc.ev(0, 6'h08);
    rd(8'h1A, 16'h071F);
    vector_mode_option = 2'b00;
    u_bc.ev(0, 6'h08);
    rd(8'h1A, 16'h061F);
    u_bc.cmd(0, 16'h1234, 16'h0456);
    cap_chk(0, 32'h1234_0456);
    rd(8'h02, 16'h1234);
    rd(8'h03, 16'h0456);
    u_bc.cmd(1, 16'h2222, 16'h0602);
    @(posedge ref_clk);
    #1 u_bc.cmd(1, 16'h3333, 16'h0603);
    cap_chk(1, 32'h3333_0603);
    terminal_soft_reset = 2'b01;
    @(posedge ref_clk);
    #1 terminal_soft_reset = 2'b00;
    rd(8'h19, 16'h0400);
    rd(8'h1A, 16'h0000);
    rd(8'h02, 16'h1234);
    rd(8'h03, 16'h0456);
    wr(8'h22, 16'hFFFF);
    rd(8'h22, 16'h7E00);
    wr(8'h23, 16'h8208);
    rd(8'h23, 16'h8208);
    chk(busy_r, 2'b10);
    terminal_soft_reset = 2'b10;
    @(posedge ref_clk);
    #1 terminal_soft_reset = 2'b00;
    rd(8'h22, 16'h0600);
    rd(8'h23, 16'h0000);
    rd(8'h04, 16'h3333);
    rd(8'h05, 16'h0603);
    rst_n = 0;
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1;
    for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
    print_verdict();
  end
endmodule
`default_nettype wire
